// >>> src/spm_pkg.sv
/*
 * Shared constants of the serial master/slave port: control and
 * configuration bit positions, reset values, select-mode encodings,
 * state encoding and master clock timing.
 * Assumes a 100 MHz system clock; nothing else is needed from outside.
 */
package spm_pkg;

	// Port control register bit positions.
	localparam int CTRL_DONE_BIT = 7; // Transfer-done flag.
	localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 6; // Write-collision flag.
	localparam int CTRL_MODE_FAULT_FLAG_BIT = 5; // Mode-fault flag.
	localparam int CTRL_SELU_BIT = 3; // Upper select-mode bit.
	localparam int CTRL_SELL_BIT = 2; // Lower select-mode bit.
	localparam int CTRL_TXE_BIT = 1; // Transmit buffer empty, read only.
	localparam int CTRL_EN_BIT = 0; // Port-enable bit.

	// Port configuration register bit positions.
	localparam int CFG_BUSY_BIT = 7; // Transfer in progress, read only.
	localparam int CFG_MST_BIT = 6; // Master-enable bit.
	localparam int CFG_CPHA_BIT = 5; // Clock-phase bit.
	localparam int CFG_CPOL_BIT = 4; // Clock-polarity bit.
	localparam int CFG_SLVSEL_BIT = 3; // Slave currently selected, read only.
	localparam int CFG_SELIN_BIT = 2; // Synchronised select input, read only.
	localparam int CFG_SHE_BIT = 1; // Shift register empty, read only.
	localparam int CFG_RXE_BIT = 0; // Receive buffer never loaded, read only.

	// Select-mode field encodings.
	localparam logic [1:0] SEL_3WIRE = 2'h0; // Three wire, select unused.
	localparam logic [1:0] SEL_MULTI = 2'h1; // Select is an input.

	// Reset values: select mode is multi-master, everything else clear.
	localparam logic [1:0] SEL_RESET = SEL_MULTI; // Select-mode field.
	localparam logic [7:0] BYTE_RESET = 8'h00; // Data buffers and shifter.

	// Serial clock edges in one byte, two per bit.
	localparam logic [3:0] LAST_EDGE = 4'hf; // Index of the sixteenth edge.

	// Master serial clock: half period as time and as cycles.
	localparam int CLK_PERIOD_NS = 10; // System clock period.
	localparam int SCK_HALF_NS = 40; // Least half period of the master clock.
	localparam logic [2:0] SCK_HALF_CYC =
		3'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS); // Rounded up.

	// Transfer sequencer states, Gray coded along idle, run, done.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RUN = 2'h1,
		ST_DONE = 2'h3
	} spm_state_t;

endpackage

// >>> src/spm_sync2.sv
/*
 * Two flip-flop synchroniser for one level from outside the clock domain.
 * Assumes the input may change at any time relative to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module spm_sync2 (
	input wire logic clk_in, // System clock.
	input wire logic rst_b_in, // Synchronous reset, active low.
	input wire logic rst_val_in, // Constant level taken during reset.
	input wire logic async_in, // Level from outside the domain.
	output logic sync_out // Level safe to use in the domain.
);

	logic meta_q; // First stage, read only by the second stage.
	logic sync_q; // Second stage.
	logic [1:0] flush_q; // Fills with ones as real samples reach the second stage.

	// The first stage is read by the second stage and nothing else.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			flush_q <= 2'h0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			flush_q <= {flush_q[0], 1'b1};
		end
	end

	// The reset level stands until a real sample has passed both stages, so no false edge follows reset.
	assign sync_out = flush_q[1] ? sync_q : rst_val_in;

endmodule
`default_nettype wire

// >>> src/spm_port.sv
/*
 * Serial master/slave port: one byte shifter with transmit and receive
 * buffers, master clock generation, slave edge sampling, select-pin modes
 * and the control, configuration and flag bits, all as plain ports.
 * Assumes software pulses the write strobes for one system clock and that
 * the pin wires are resolved from the output enables outside.
 */
`timescale 1ns/100ps
`default_nettype none
module spm_port (
	input wire logic core_clk_in, // System clock, 100 MHz.
	input wire logic rst_b_in, // Synchronous reset, active low.
	input wire logic ctrl_wr_in, // Write strobe for the control register.
	input wire logic [7:0] ctrl_wdata_in, // Control register write data.
	input wire logic cfg_wr_in, // Write strobe for the configuration register.
	input wire logic [7:0] cfg_wdata_in, // Configuration register write data.
	input wire logic data_wr_in, // Write strobe for the data window.
	input wire logic [7:0] data_wdata_in, // Byte written to the data window.
	input wire logic int_enable_in, // Interrupt enable from the system.
	output logic [7:0] port_control_out, // Control register read value.
	output logic [7:0] port_config_out, // Configuration register read value.
	output logic [7:0] data_window_out, // Receive buffer, read through the window.
	output logic irq_out, // Interrupt request, registered level.
	input wire logic sck_in, // Serial clock pin level.
	output logic sck_out, // Serial clock driven as master.
	output logic sck_oe_out, // Serial clock output enable.
	input wire logic mosi_in, // MOSI pin level.
	output logic mosi_out, // MOSI driven as master.
	output logic mosi_oe_out, // MOSI output enable.
	input wire logic miso_in, // MISO pin level.
	output logic miso_out, // MISO driven as slave.
	output logic miso_oe_out, // MISO output enable.
	input wire logic sel_in, // Slave-select pin level.
	output logic sel_out, // Slave-select driven level.
	output logic sel_oe_out, // Slave-select output enable.
	output logic sel_pin_mapped_out // High while the select line owns a pin.
);

	// Control and configuration state.
	logic port_enable_bit_q; // Port enable.
	logic master_enable_bit_q; // Master mode.
	logic clock_phase_bit_q; // Latching edge select.
	logic clock_polarity_bit_q; // Idle level of the clock.
	logic [1:0] select_mode_field_q; // Select-line behaviour.
	logic transfer_done_flag_q; // Byte finished.
	logic write_collision_flag_q; // Write to a full transmit buffer.
	logic mode_fault_flag_q; // Another master pulled select low.
	logic rx_loaded_q; // Receive buffer has been loaded once.
	logic irq_q; // Registered interrupt request.

	// Data path state.
	logic [7:0] tx_buf_q; // Transmit buffer.
	logic tx_full_q; // Transmit buffer holds a byte.
	logic [7:0] shift_q; // Byte shifter.
	logic shift_empty_q; // Shifter holds no pending byte.
	logic [7:0] rx_buf_q; // Receive buffer.
	logic bit_q; // Bit latched on a sample edge.
	logic [3:0] edge_q; // Serial clock edges seen in this byte.
	logic [2:0] div_q; // Master half-period counter.
	logic sck_q; // Master serial clock level.
	spm_pkg::spm_state_t st_q; // Transfer sequencer.

	// Synchronised pins and edge history.
	logic sck_s; // Synchronised serial clock.
	logic sel_s; // Synchronised select input.
	logic mosi_s; // Synchronised MOSI.
	logic miso_s; // Synchronised MISO.
	logic sck_prev_q; // Serial clock one cycle back.
	logic sel_prev_q; // Select input one cycle back.

	// Combinational decode.
	logic is_master; // Enabled master.
	logic is_slave; // Enabled slave.
	logic slave_sel; // Slave is selected.
	logic sel_fall; // Select input went from high to low.
	logic mode_fault; // Multi-master fault this cycle.
	logic edge_ev; // One serial clock edge to process.
	logic sample_edge; // This edge latches a data bit.
	logic in_bit; // Incoming serial data bit.
	logic load_go; // Move transmit buffer into the shifter.
	logic last_ev; // Final edge of a byte.
	logic [7:0] new_byte; // Byte completed on the final edge.

	// Every pin input passes two flops before any logic reads it.
	spm_sync2 u_sync_sck (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .rst_val_in(1'b0),
		.async_in(sck_in), .sync_out(sck_s));
	spm_sync2 u_sync_sel (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .rst_val_in(1'b1),
		.async_in(sel_in), .sync_out(sel_s));
	spm_sync2 u_sync_mosi (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .rst_val_in(1'b0),
		.async_in(mosi_in), .sync_out(mosi_s));
	spm_sync2 u_sync_miso (.clk_in(core_clk_in), .rst_b_in(rst_b_in), .rst_val_in(1'b0),
		.async_in(miso_in), .sync_out(miso_s));

	// Edge history of the synchronised clock and select levels.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			sck_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck_s;
			sel_prev_q <= sel_s;
		end
	end

	// Role decode from the enable bits and the select mode.
	always_comb begin
		is_master = port_enable_bit_q && master_enable_bit_q;
		is_slave = port_enable_bit_q && !master_enable_bit_q;
		// Mode 00 selects the slave for good; mode 01 selects on a low input.
		slave_sel = (select_mode_field_q == spm_pkg::SEL_3WIRE) ||
			((select_mode_field_q == spm_pkg::SEL_MULTI) && !sel_s);
		sel_fall = sel_prev_q && !sel_s;
		// A low select in multi-master mode throws the master off the bus.
		mode_fault = is_master && (select_mode_field_q == spm_pkg::SEL_MULTI) &&
			!sel_s;
	end

	// Edge source: own divider as master, sampled pin clock as slave.
	always_comb begin
		if (is_master) begin
			edge_ev = (st_q == spm_pkg::ST_RUN) &&
				(div_q == 3'(spm_pkg::SCK_HALF_CYC - 3'h1));
			in_bit = miso_s;
		end else begin
			// A deselected four-wire slave never sees clock activity.
			edge_ev = is_slave && slave_sel && (sck_s != sck_prev_q) &&
				(st_q != spm_pkg::ST_DONE);
			in_bit = mosi_s;
		end
		// Even edges are leading edges; phase 0 samples on them.
		sample_edge = (edge_q[0] == clock_phase_bit_q);
		last_ev = edge_ev && (edge_q == spm_pkg::LAST_EDGE);
		new_byte = {shift_q[6:0], clock_phase_bit_q ? in_bit : bit_q};
		load_go = tx_full_q && shift_empty_q && port_enable_bit_q &&
			(st_q == spm_pkg::ST_IDLE) && (edge_q == 4'h0);
	end

	// Control bits: software writes, with a mode fault taking precedence.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			port_enable_bit_q <= 1'b0;
			master_enable_bit_q <= 1'b0;
			clock_phase_bit_q <= 1'b0;
			clock_polarity_bit_q <= 1'b0;
			select_mode_field_q <= spm_pkg::SEL_RESET;
		end else begin
			if (ctrl_wr_in) begin
				port_enable_bit_q <= ctrl_wdata_in[spm_pkg::CTRL_EN_BIT];
				select_mode_field_q <= {ctrl_wdata_in[spm_pkg::CTRL_SELU_BIT],
					ctrl_wdata_in[spm_pkg::CTRL_SELL_BIT]};
			end
			if (cfg_wr_in) begin
				master_enable_bit_q <= cfg_wdata_in[spm_pkg::CFG_MST_BIT];
				clock_phase_bit_q <= cfg_wdata_in[spm_pkg::CFG_CPHA_BIT];
				clock_polarity_bit_q <= cfg_wdata_in[spm_pkg::CFG_CPOL_BIT];
			end
			// The fault wins over a same-cycle write and holds until rewritten.
			if (mode_fault) begin
				port_enable_bit_q <= 1'b0;
				master_enable_bit_q <= 1'b0;
			end
		end
	end

	// Event flags: hardware set wins over a software clear by writing 0.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			transfer_done_flag_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
		end else begin
			if (last_ev) begin
				transfer_done_flag_q <= 1'b1;
			end else if (ctrl_wr_in) begin
				transfer_done_flag_q <= transfer_done_flag_q &
					ctrl_wdata_in[spm_pkg::CTRL_DONE_BIT];
			end
			if (data_wr_in && tx_full_q) begin
				write_collision_flag_q <= 1'b1;
			end else if (ctrl_wr_in) begin
				write_collision_flag_q <= write_collision_flag_q &
					ctrl_wdata_in[spm_pkg::CTRL_WRITE_COLLISION_FLAG_BIT];
			end
			if (mode_fault) begin
				mode_fault_flag_q <= 1'b1;
			end else if (ctrl_wr_in) begin
				mode_fault_flag_q <= mode_fault_flag_q &
					ctrl_wdata_in[spm_pkg::CTRL_MODE_FAULT_FLAG_BIT];
			end
		end
	end

	// Interrupt request follows any set flag while interrupts are enabled.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= int_enable_in && (transfer_done_flag_q ||
				write_collision_flag_q || mode_fault_flag_q);
		end
	end

	// Transmit buffer: a write to a full buffer is dropped untouched.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			tx_buf_q <= spm_pkg::BYTE_RESET;
			tx_full_q <= 1'b0;
		end else begin
			if (data_wr_in && !tx_full_q) begin
				tx_buf_q <= data_wdata_in;
				tx_full_q <= 1'b1;
			end else if (load_go) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	// Shifter: loaded from the buffer, shifted on edges, emptied per byte.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			shift_q <= spm_pkg::BYTE_RESET;
			shift_empty_q <= 1'b1;
			bit_q <= 1'b0;
		end else begin
			if (load_go) begin
				shift_q <= tx_buf_q;
				shift_empty_q <= 1'b0;
			end else if (last_ev) begin
				// The received byte stays in the shifter until the next load or, as slave, the shift edges of the next byte.
				shift_q <= new_byte;
				shift_empty_q <= 1'b1;
			end else if (edge_ev && sample_edge) begin
				bit_q <= in_bit;
			end else if (edge_ev && !(clock_phase_bit_q && edge_q == 4'h0)) begin
				// Phase 1 has nothing latched before its first leading edge.
				shift_q <= {shift_q[6:0], bit_q};
			end
		end
	end

	// Receive buffer is written only at the end of a whole byte.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			rx_buf_q <= spm_pkg::BYTE_RESET;
			rx_loaded_q <= 1'b0;
		end else if (last_ev) begin
			rx_buf_q <= new_byte;
			rx_loaded_q <= 1'b1;
		end
	end

	// Bit counter: cleared by disable and by a falling select in four-wire slave.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			edge_q <= 4'h0;
		end else if (!port_enable_bit_q) begin
			edge_q <= 4'h0;
		end else if (is_slave && select_mode_field_q == spm_pkg::SEL_MULTI && sel_fall) begin
			edge_q <= 4'h0;
		end else if (edge_ev) begin
			edge_q <= edge_q + 4'h1;
		end
	end

	// Sequencer: idle, running, one done cycle, back to idle.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			st_q <= spm_pkg::ST_IDLE;
		end else if (!port_enable_bit_q || mode_fault) begin
			st_q <= spm_pkg::ST_IDLE;
		end else begin
			case (st_q)
				spm_pkg::ST_IDLE: begin
					// A master starts on load; a slave starts on its first edge.
					if ((is_master && load_go) || (is_slave && edge_ev)) begin
						st_q <= spm_pkg::ST_RUN;
					end
				end
				spm_pkg::ST_RUN: begin
					if (last_ev) begin
						st_q <= spm_pkg::ST_DONE;
					end else if (is_slave && sel_fall &&
						select_mode_field_q == spm_pkg::SEL_MULTI) begin
						st_q <= spm_pkg::ST_IDLE;
					end
				end
				// The done state and any stray code both fall back to idle.
				default: begin
					st_q <= spm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Master clock: half periods counted, level toggled on every edge.
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			div_q <= 3'h0;
			sck_q <= 1'b0;
		end else if (!is_master || st_q != spm_pkg::ST_RUN) begin
			div_q <= 3'h0;
			sck_q <= clock_polarity_bit_q;
		end else if (edge_ev) begin
			div_q <= 3'h0;
			sck_q <= !sck_q;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Pin drive by role, released when disabled except the select pin, then register read-back.
	always_comb begin
		sck_out = sck_q;
		sck_oe_out = is_master;
		mosi_out = shift_q[7];
		mosi_oe_out = is_master;
		miso_out = shift_q[7];
		miso_oe_out = is_slave && slave_sel;
		// Software owns the select level when the upper mode bit is set.
		sel_out = select_mode_field_q[0];
		sel_oe_out = select_mode_field_q[1];
		sel_pin_mapped_out = (select_mode_field_q != spm_pkg::SEL_3WIRE);
		// Register read-back and status.
		port_control_out = 8'h00;
		port_control_out[spm_pkg::CTRL_DONE_BIT] = transfer_done_flag_q;
		port_control_out[spm_pkg::CTRL_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_q;
		port_control_out[spm_pkg::CTRL_MODE_FAULT_FLAG_BIT] = mode_fault_flag_q;
		port_control_out[spm_pkg::CTRL_SELU_BIT] = select_mode_field_q[1];
		port_control_out[spm_pkg::CTRL_SELL_BIT] = select_mode_field_q[0];
		port_control_out[spm_pkg::CTRL_TXE_BIT] = !tx_full_q;
		port_control_out[spm_pkg::CTRL_EN_BIT] = port_enable_bit_q;
		port_config_out = 8'h00;
		port_config_out[spm_pkg::CFG_BUSY_BIT] = (st_q != spm_pkg::ST_IDLE);
		port_config_out[spm_pkg::CFG_MST_BIT] = master_enable_bit_q;
		port_config_out[spm_pkg::CFG_CPHA_BIT] = clock_phase_bit_q;
		port_config_out[spm_pkg::CFG_CPOL_BIT] = clock_polarity_bit_q;
		port_config_out[spm_pkg::CFG_SLVSEL_BIT] = is_slave && slave_sel;
		port_config_out[spm_pkg::CFG_SELIN_BIT] = sel_s;
		port_config_out[spm_pkg::CFG_SHE_BIT] = shift_empty_q;
		port_config_out[spm_pkg::CFG_RXE_BIT] = !rx_loaded_q;
		data_window_out = rx_buf_q;
		irq_out = irq_q;
	end

endmodule
`default_nettype wire

// >>> bench/spm_port_properties.sv
/* Checker for the serial port: sees only the top module ports.
   Assumes a bind from the bench top file. */
`timescale 1ns/100ps
`default_nettype none
module spm_port_properties (
	input wire logic core_clk_in, // System clock.
	input wire logic rst_b_in, // Reset, active low.
	input wire logic ctrl_wr_in, // Control strobe.
	input wire logic data_wr_in, // Data strobe.
	input wire logic int_enable_in, // Interrupt enable.
	input wire logic [7:0] port_control_out, // Control read.
	input wire logic [7:0] port_config_out, // Config read.
	input wire logic irq_out, // Interrupt.
	input wire logic sck_out, // Master clock.
	input wire logic sck_oe_out, // Clock enable.
	input wire logic mosi_oe_out, // MOSI enable.
	input wire logic miso_oe_out, // MISO enable.
	input wire logic sel_out, // Select level.
	input wire logic sel_oe_out, // Select enable.
	input wire logic sel_pin_mapped_out // Select pin mapped.
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_mosi_owner: assert property (mosi_oe_out |-> port_control_out[0] && port_config_out[6])
		else $error("mosi driven outside master mode");
	a_miso_release: assert property (!port_control_out[0] || port_config_out[6] ||
		(port_control_out[3:2] == 2'h1 && port_config_out[2]) |-> !miso_oe_out)
		else $error("miso driven while it should float");
	a_sel_drive: assert property (sel_oe_out == port_control_out[3] &&
		(!sel_oe_out || sel_out == port_control_out[2])) else $error("select output wrong");
	a_sel_pin: assert property (sel_pin_mapped_out == (port_control_out[3:2] != 2'h0))
		else $error("select pin mapping wrong");
	a_fault_clear: assert property ($rose(port_control_out[5]) |->
		!port_control_out[0] && !port_config_out[6]) else $error("fault left port enabled");
	a_stay_off: assert property (!port_control_out[0] && !ctrl_wr_in |=> !port_control_out[0])
		else $error("port enabled itself");
	a_irq_level: assert property (int_enable_in && port_control_out[7] |=> irq_out)
		else $error("no interrupt on done");
	a_write_collision_flag_set: assert property (data_wr_in && !port_control_out[1] |=> port_control_out[6])
		else $error("collision flag not set");
	a_master_start: assert property (data_wr_in && port_control_out[1] && port_control_out[0] &&
		port_config_out[6] && !port_config_out[7] |-> ##[1:3] port_config_out[7])
		else $error("master transfer did not start");
	a_byte_time: assert property ($rose(port_config_out[7]) && port_config_out[6] |->
		##[63:65] $rose(port_control_out[7])) else $error("master byte time wrong");
	a_sck_idle: assert property (!port_config_out[7] && sck_oe_out &&
		$stable(port_config_out[4]) |-> sck_out == port_config_out[4]) else $error("sck not idle");
	c_done: cover property ($rose(port_control_out[7]));
	c_fault: cover property ($rose(port_control_out[5]));
	c_write_collision_flag: cover property ($rose(port_control_out[6]));
endmodule
`default_nettype wire

// >>> bench/spm_slave_model.sv
/* Behavioural external slave on the far side of the port.
   Assumes mode 0 clocking and a load pulse before each frame. */
`timescale 1ns/100ps
`default_nettype none
module spm_slave_model (
	input wire logic sck_in, // Serial clock from the master.
	input wire logic mosi_in, // Data from the master.
	input wire logic sel_in, // High while addressed.
	input wire logic load_in, // Loads the reply byte.
	input wire logic [7:0] reply_in, // Reply byte.
	output logic miso_out, // Data to the master.
	output logic [7:0] rx_out // Byte received.
);
	logic [7:0] sh_q = 8'h00; // Reply shifter.
	// Samples on the leading rising edge, MSB first.
	always @(posedge sck_in) begin
		if (sel_in) begin
			rx_out <= {rx_out[6:0], mosi_in};
		end
	end
	// Shifts the reply out on the trailing edge, alongside the master.
	always @(negedge sck_in or posedge load_in) begin
		if (load_in) begin
			sh_q <= reply_in;
		end else if (sel_in) begin
			sh_q <= {sh_q[6:0], 1'b0};
		end
	end
	// A released line shows the inverse, so a stale bit cannot pass.
	assign miso_out = sel_in ? sh_q[7] : ~sh_q[7];
endmodule
`default_nettype wire

// >>> bench/spm_port_bench.sv
/* Self-checking bench for the serial port with an external slave.
   Assumes nothing outside; it makes both clocks itself. */
`timescale 1ns/100ps
`default_nettype none
module spm_port_bench;
	logic core_clk_in = 1'b0, link_clk = 1'b0, rst_b_in = 1'b0; // Clocks, reset.
	logic ctrl_wr_in = 1'b0, cfg_wr_in = 1'b0, data_wr_in = 1'b0; // Strobes.
	logic [7:0] ctrl_wdata_in = 8'h00, cfg_wdata_in = 8'h00, data_wdata_in = 8'h00; // Data.
	logic int_enable_in = 1'b1; // Interrupts on.
	logic [7:0] port_control_out, port_config_out, data_window_out; // Reads.
	logic irq_out, sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out; // Pins.
	logic sel_out, sel_oe_out, sel_pin_mapped_out, slv_miso; // Pins.
	logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_sel = 1'b1, load = 1'b0; // Bench drives.
	logic [7:0] slv_rx, rx; // Received bytes.
	logic [10:0] rows [4] = '{11'h000, 11'h023, 11'h045, 11'h067}; // Control, sel oe/out/map.
	int miscompares = 0, cmp_count = 0; // Counters.
	// Pin levels resolved from the port's output enables.
	wire logic sck_w = sck_oe_out ? sck_out : tb_sck;
	wire logic mosi_w = mosi_oe_out ? mosi_out : tb_mosi;
	wire logic miso_w = miso_oe_out ? miso_out : slv_miso;
	wire logic sel_w = sel_oe_out ? sel_out : tb_sel;
	spm_port i_spm_port (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .ctrl_wr_in(ctrl_wr_in),
		.ctrl_wdata_in(ctrl_wdata_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in),
		.data_wr_in(data_wr_in), .data_wdata_in(data_wdata_in), .int_enable_in(int_enable_in),
		.port_control_out(port_control_out), .port_config_out(port_config_out),
		.data_window_out(data_window_out), .irq_out(irq_out), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe_out(sck_oe_out), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
		.miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .sel_in(sel_w),
		.sel_out(sel_out), .sel_oe_out(sel_oe_out), .sel_pin_mapped_out(sel_pin_mapped_out));
	// Only one slave hangs on the three-wire bus.
	spm_slave_model i_spm_slave_model (.sck_in(sck_w), .mosi_in(mosi_w), .sel_in(mosi_oe_out),
		.load_in(load), .reply_in(8'h3c), .miso_out(slv_miso), .rx_out(slv_rx));
	// System clock 100 MHz and an unrelated 64 ns link clock.
	always #5 core_clk_in = ~core_clk_in;
	always #32 link_clk = ~link_clk;
	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe: 0 control, 1 config, 2 data.
	task automatic wr(input int k, input logic [7:0] d);
		@(negedge core_clk_in);
		ctrl_wr_in = (k == 0);
		cfg_wr_in = (k == 1);
		data_wr_in = (k == 2);
		{ctrl_wdata_in, cfg_wdata_in, data_wdata_in} = {d, d, d};
		@(negedge core_clk_in);
		{ctrl_wr_in, cfg_wr_in, data_wr_in} = 3'h0;
	endtask
	// Bench acts as mode 0 master, one bit per two link cycles.
	task automatic spi_byte(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			@(posedge link_clk);
			tb_sck = 1'b0;
			tb_mosi = tx[i];
			@(posedge link_clk);
			tb_sck = 1'b1;
			rx[i] = miso_w;
		end
		@(posedge link_clk);
		tb_sck = 1'b0;
	endtask
	// Waits, bounded, for the done flag.
	task automatic wait_done;
		for (int n = 0; n < 300 && port_control_out[7] !== 1'b1; n++) begin
			@(negedge core_clk_in);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Cuts a hang short.
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
	// Main sequence: reset, mode table, then the awkward cases.
	initial begin
		repeat (10) @(negedge core_clk_in);
		chk(port_control_out, 8'h06);
		chk(port_config_out, 8'h07);
		rst_b_in = 1'b1;
		chk({6'h00, mosi_oe_out, miso_oe_out}, 8'h00);
		wr(1, 8'h40);
		for (int r = 0; r < 4; r++) begin
			wr(0, rows[r][10:3]);
			chk({5'h00, sel_oe_out, sel_out, sel_pin_mapped_out}, {5'h00, rows[r][2:0]});
		end
		wr(0, 8'h01);
		load = 1'b1;
		#1 load = 1'b0;
		// Two writes back to back: the second must collide.
		@(negedge core_clk_in);
		data_wdata_in = 8'ha5;
		data_wr_in = 1'b1;
		@(negedge core_clk_in);
		data_wdata_in = 8'h77;
		@(negedge core_clk_in);
		data_wr_in = 1'b0;
		wait_done();
		chk(data_window_out, 8'h3c);
		chk(slv_rx, 8'ha5);
		chk(port_control_out & 8'hc0, 8'hc0);
		@(negedge core_clk_in);
		chk({7'h00, irq_out}, 8'h01);
		// Another master pulls select low in multi-master mode.
		wr(0, 8'h05);
		tb_sel = 1'b0;
		repeat (6) @(negedge core_clk_in);
		chk(port_control_out & 8'h21, 8'h20);
		chk(port_config_out & 8'h40, 8'h00);
		tb_sel = 1'b1;
		repeat (6) @(negedge core_clk_in);
		chk(port_control_out & 8'h01, 8'h00);
		// Four-wire slave: clocks while deselected are ignored.
		wr(1, 8'h00);
		wr(0, 8'h05);
		wr(2, 8'h5a);
		spi_byte(8'hff);
		@(negedge core_clk_in);
		chk(port_control_out & 8'h80, 8'h00);
		chk({7'h00, miso_oe_out}, 8'h00);
		tb_sel = 1'b0;
		repeat (4) @(negedge core_clk_in);
		chk({7'h00, miso_oe_out}, 8'h01);
		spi_byte(8'hc3);
		repeat (10) @(negedge core_clk_in);
		chk(data_window_out, 8'hc3);
		chk(rx, 8'h5a);
		chk(port_control_out & 8'h80, 8'h80);
		// Three-wire slave drives its data line, checked with the select pin still held low.
		wr(0, 8'h01);
		chk({7'h00, miso_oe_out}, 8'h01);
		tb_sel = 1'b1;
		complete_run();
	end
endmodule
bind spm_port spm_port_properties i_spm_port_properties (.core_clk_in(core_clk_in),
	.rst_b_in(rst_b_in), .ctrl_wr_in(ctrl_wr_in), .data_wr_in(data_wr_in),
	.int_enable_in(int_enable_in), .port_control_out(port_control_out),
	.port_config_out(port_config_out), .irq_out(irq_out), .sck_out(sck_out),
	.sck_oe_out(sck_oe_out), .mosi_oe_out(mosi_oe_out), .miso_oe_out(miso_oe_out),
	.sel_out(sel_out), .sel_oe_out(sel_oe_out), .sel_pin_mapped_out(sel_pin_mapped_out));
`default_nettype wire
